//--- switch_register_space_global_ctrl.sv
// management register front end: address decode and global operation registers
// assumes byte requests from spi, i2c, in-band or miim logic on the same clock,
// and a downstream register fabric that answers forwarded reads in the same cycle
`timescale 1ns/100ps

// Overview of operation
// R1 - switch registers via spi, i2c, in-band only
// R2 - miim switch accesses refused, phy pages only
// R3 - address split into port, page, register
// R4 - port zero global, ports one to seven
// R5 - host keeps address bit fifteen zero
// R6 - every byte accessed alone, any order
// R7 - most significant byte at lowest address
// R8 - global pages grouped, pages six up reserved
// R9 - port pages grouped, 2, 7, d-f reserved
// R10 - host never writes reserved space
// R11 - host merges reserved bits by read-or-write
// R12 - soft reset bit pulses, self clears
// R13 - power-event pin enable and polarity bits
// R14 - status bit 31 shows lookup engine request
// R15 - status bit 30 shows gpio/timestamp request
// R16 - status pending reads one, reserved zero
// R17 - mask bits 31, 30 disable sources
// R18 - reserved bits read zero, ignore writes
module switch_register_space_global_ctrl
  import switch_regs_pkg::*;
#(
  parameter logic [7:0] CHIP_ID0 = 8'h5a,  // arbitrary identity value
  parameter logic [7:0] CHIP_ID1 = 8'h3c,  // arbitrary identity value
  parameter logic [7:0] CHIP_ID2 = 8'hc3,  // arbitrary identity value
  parameter logic [3:0] REV_ID   = 4'h1    // arbitrary revision value
) (
  input  wire logic                clk,             // system clock
  input  wire logic                srst,            // synchronous reset, active high
  input  wire logic                reqValid,        // byte request strobe
  input  wire logic                reqWrite,        // 1 write, 0 read
  input  wire logic [ADDR_W-1:0]   reqAddr,         // byte address
  input  wire logic [7:0]          reqWdata,        // write byte
  input  wire mgmt_path_t          reqPath,         // path that carried the request
  output logic                     rspValid_r,      // answer strobe
  output logic [7:0]               rspRdata_r,      // read byte
  output logic                     rspError_r,      // access refused
  output logic                     fwdValid_r,      // forwarded access strobe
  output logic                     fwdWrite_r,      // forwarded write
  output logic [PORT_W-1:0]        fwdPort_r,       // decoded port field
  output logic [PAGE_W-1:0]        fwdPage_r,       // decoded page field
  output logic [REG_W-1:0]         fwdReg_r,        // decoded register field
  output logic [7:0]               fwdWdata_r,      // forwarded write byte
  input  wire logic [7:0]          fwdRdata,        // downstream read byte
  input  wire logic                lookupEngineIrq, // lookup engine request level
  input  wire logic                gpioTsIrq,       // gpio trigger/timestamp level
  input  wire logic                powerEventReq,   // power event pending
  output logic                     softReset_r,     // datapath reset pulse
  output logic                     globalIrq_r,     // unmasked global request
  output logic                     powerEventPin_r, // power-event pin level
  output logic                     powerEventOeN_r  // power-event pin enable, low drives
);


  // decode helpers


  // register byte handled by this bank
  function automatic logic isLocalByte(input logic [7:0] r);
    isLocalByte = (r <= OFS_REV_RST) || (r == OFS_PME_CTL) ||
                  ((r >= OFS_INT_STATUS) && (r <= OFS_INT_MASK + 8'h03));
  endfunction

  // classify an address for the path that carried it
  function automatic region_t classify(input logic [ADDR_W-1:0] a, input mgmt_path_t p);
    logic [3:0] port;
    logic [3:0] page;
    port = a[PORT_LSB +: PORT_W];   // R3
    page = a[PAGE_LSB +: PAGE_W];   // R3
    if (a[ADDR_TOP_BIT]) begin
      classify = RG_REFUSED;        // R5
    end else if (p == PATH_MIIM) begin
      // miim reaches only the per-port phy pages
      if (port != GLOBAL_PORT && page == PORT_PHY_PAGE) begin
        classify = RG_FORWARD;      // R1
      end else begin
        classify = RG_REFUSED;      // R2
      end
    end else if (port == GLOBAL_PORT) begin
      if (page == GLB_OP_PAGE && isLocalByte(a[REG_LSB +: REG_W])) begin
        classify = RG_LOCAL;        // R4
      end else if (page <= GLB_PAGE_LAST) begin
        classify = RG_FORWARD;      // R8
      end else begin
        classify = RG_RESERVED;     // R8
      end
    end else if (page == PORT_RSVD_PG_A || page == PORT_RSVD_PG_B ||
                 page >= PORT_RSVD_PG_HI) begin
      classify = RG_RESERVED;       // R9
    end else begin
      classify = RG_FORWARD;        // R4
    end
  endfunction

  // pick one byte of a word, most significant byte at the lowest offset
  function automatic logic [7:0] wordByte(input logic [31:0] w, input logic [1:0] idx);
    wordByte = w[8*(3-idx) +: 8];   // R7
  endfunction


  // state

  logic                   s1Valid_r,  s1Valid_nxt;   // stage one holds a request
  logic                   s1Write_r,  s1Write_nxt;   // stage one direction
  logic [REG_W-1:0]       s1Reg_r,    s1Reg_nxt;     // stage one register byte
  logic [7:0]             s1Wdata_r,  s1Wdata_nxt;   // stage one write byte
  region_t                s1Region_r, s1Region_nxt;  // stage one decode
  logic                   fwdValid_nxt;              // next forward strobe
  logic                   fwdWrite_nxt;              // next forward direction
  logic [PORT_W-1:0]      fwdPort_nxt;               // next port field
  logic [PAGE_W-1:0]      fwdPage_nxt;               // next page field
  logic [REG_W-1:0]       fwdReg_nxt;                // next register field
  logic [7:0]             fwdWdata_nxt;              // next forward data
  logic                   rspValid_nxt;              // next answer strobe
  logic [7:0]             rspRdata_nxt;              // next answer byte
  logic                   rspError_nxt;              // next refusal flag
  logic [1:0]             pmeCtl_r,    pmeCtl_nxt;   // enable, polarity
  logic [1:0]             intMask_r,   intMask_nxt;  // lookup, gpio masks
  logic [1:0]             intStatus_r, intStatus_nxt;// lookup, gpio pending
  logic [SWRST_CNT_W-1:0] swRstCnt_r,  swRstCnt_nxt; // soft reset countdown
  logic                   softReset_nxt;             // next reset pulse level
  logic                   globalIrq_nxt;             // next combined request
  logic [31:0]            statusWord;                // status as a word
  logic [31:0]            maskWord;                  // mask as a word
  logic [7:0]             localRdata;                // local read byte

  // status and mask as full words, reserved bits zero
  assign statusWord = {intStatus_r, 30'h0};          // R16
  assign maskWord   = {intMask_r, 30'h0};            // R18

  // local read mux for the byte in stage one
  always_comb begin
    localRdata = 8'h00;
    case (s1Reg_r)
      OFS_CHIP_ID0: localRdata = CHIP_ID0;
      OFS_CHIP_ID1: localRdata = CHIP_ID1;
      OFS_CHIP_ID2: localRdata = CHIP_ID2;
      OFS_REV_RST:  localRdata = {REV_ID, 3'h0, softReset_r};    // R18
      OFS_PME_CTL:  localRdata = {6'h00, pmeCtl_r};              // R18
      default: begin
        if (s1Reg_r >= OFS_INT_MASK) begin
          localRdata = wordByte(maskWord, s1Reg_r[1:0]);        // R6
        end else if (s1Reg_r >= OFS_INT_STATUS) begin
          localRdata = wordByte(statusWord, s1Reg_r[1:0]);      // R6
        end else begin
          localRdata = 8'h00;
        end
      end
    endcase
  end


  // access pipeline: decode in stage one, answer in stage two

  always_comb begin
    s1Valid_nxt  = reqValid;
    s1Write_nxt  = reqWrite;
    s1Reg_nxt    = reqAddr[REG_LSB +: REG_W];
    s1Wdata_nxt  = reqWdata;
    s1Region_nxt = classify(reqAddr, reqPath);
    // forward strobe goes out in the cycle after the request
    fwdValid_nxt = reqValid && (s1Region_nxt == RG_FORWARD);      // R3
    fwdWrite_nxt = reqWrite;
    fwdPort_nxt  = reqAddr[PORT_LSB +: PORT_W];                   // R4
    fwdPage_nxt  = reqAddr[PAGE_LSB +: PAGE_W];
    fwdReg_nxt   = reqAddr[REG_LSB +: REG_W];
    fwdWdata_nxt = reqWdata;
    // answer one cycle after stage one
    rspValid_nxt = s1Valid_r;
    rspError_nxt = 1'b0;
    rspRdata_nxt = 8'h00;
    if (s1Valid_r) begin
      case (s1Region_r)
        RG_LOCAL:    rspRdata_nxt = s1Write_r ? 8'h00 : localRdata;
        RG_FORWARD:  rspRdata_nxt = s1Write_r ? 8'h00 : fwdRdata;
        RG_RESERVED: rspRdata_nxt = 8'h00;                        // R10
        RG_REFUSED:  rspError_nxt = 1'b1;                         // R2
        default:     rspError_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s1Valid_r  <= 1'b0;
      s1Write_r  <= 1'b0;
      s1Reg_r    <= 8'h00;
      s1Wdata_r  <= 8'h00;
      s1Region_r <= RG_RESERVED;
      fwdValid_r <= 1'b0;
      fwdWrite_r <= 1'b0;
      fwdPort_r  <= 4'h0;
      fwdPage_r  <= 4'h0;
      fwdReg_r   <= 8'h00;
      fwdWdata_r <= 8'h00;
      rspValid_r <= 1'b0;
      rspRdata_r <= 8'h00;
      rspError_r <= 1'b0;
    end else begin
      s1Valid_r  <= s1Valid_nxt;
      s1Write_r  <= s1Write_nxt;
      s1Reg_r    <= s1Reg_nxt;
      s1Wdata_r  <= s1Wdata_nxt;
      s1Region_r <= s1Region_nxt;
      fwdValid_r <= fwdValid_nxt;
      fwdWrite_r <= fwdWrite_nxt;
      fwdPort_r  <= fwdPort_nxt;
      fwdPage_r  <= fwdPage_nxt;
      fwdReg_r   <= fwdReg_nxt;
      fwdWdata_r <= fwdWdata_nxt;
      rspValid_r <= rspValid_nxt;
      rspRdata_r <= rspRdata_nxt;
      rspError_r <= rspError_nxt;
    end
  end


  // global operation registers: writes, soft reset, interrupts

  always_comb begin
    logic localWr;
    localWr       = s1Valid_r && s1Write_r && (s1Region_r == RG_LOCAL);
    pmeCtl_nxt    = pmeCtl_r;
    intMask_nxt   = intMask_r;
    swRstCnt_nxt  = (swRstCnt_r != '0) ? swRstCnt_r - 1'b1 : swRstCnt_r;
    // only bits 1:0 of the pin control byte store; upper bits ignored
    if (localWr && s1Reg_r == OFS_PME_CTL) begin
      pmeCtl_nxt = s1Wdata_r[1:0];                                // R18
    end
    // top mask byte holds bits 31:24; only 31 and 30 store
    if (localWr && s1Reg_r == OFS_INT_MASK) begin
      intMask_nxt = s1Wdata_r[TOP_BYTE_LUE:TOP_BYTE_GPIO];        // R17
    end
    // writing one starts the pulse; writing zero does nothing
    if (localWr && s1Reg_r == OFS_REV_RST && s1Wdata_r[SWRST_BIT]) begin
      swRstCnt_nxt = SWRST_CNT_W'(SWRST_CYCLES);                  // R12
    end
    softReset_nxt = (swRstCnt_nxt != '0);                         // R12
    // status follows the pending source levels
    intStatus_nxt = {lookupEngineIrq, gpioTsIrq};                 // R14
    globalIrq_nxt = |(intStatus_r & ~intMask_r);                  // R17
  end

  // register values survive the soft reset; only srst restores them
  always_ff @(posedge clk) begin
    if (srst) begin
      pmeCtl_r    <= PME_CTL_RST;
      intMask_r   <= INT_MASK_RST;
      intStatus_r <= INT_STATUS_RST;
      swRstCnt_r  <= '0;
      softReset_r <= 1'b0;
      globalIrq_r <= 1'b0;
    end else begin
      pmeCtl_r    <= pmeCtl_nxt;
      intMask_r   <= intMask_nxt;
      intStatus_r <= intStatus_nxt;                               // R15
      swRstCnt_r  <= swRstCnt_nxt;
      softReset_r <= softReset_nxt;
      globalIrq_r <= globalIrq_nxt;
    end
  end

  // power-event pin driver
  power_event_pin_drive u_pin (
    .clk        (clk),
    .srst       (srst),
    .pinEnable  (pmeCtl_r[PME_EN_BIT]),                           // R13
    .pinPolHigh (pmeCtl_r[PME_POL_BIT]),
    .request    (powerEventReq),
    .pinOut_r   (powerEventPin_r),
    .pinOeN_r   (powerEventOeN_r)
  );


  // assertions

  property p_miim_refused; // R2
    @(posedge clk) disable iff (srst)
      reqValid && reqPath == PATH_MIIM && reqAddr[PAGE_LSB +: PAGE_W] != PORT_PHY_PAGE
      |-> ##2 rspValid_r && rspError_r;
  endproperty
  a_miim_refused: assert property (p_miim_refused) else $error("miim switch access taken");

  property p_path_ok; // R1
    @(posedge clk) disable iff (srst)
      reqValid && reqPath != PATH_MIIM && !reqAddr[ADDR_TOP_BIT]
      |-> ##2 rspValid_r && !rspError_r;
  endproperty
  a_path_ok: assert property (p_path_ok) else $error("management access wrongly refused");

  property p_fwd_fields; // R3
    @(posedge clk) disable iff (srst)
      fwdValid_r |-> fwdPage_r == $past(reqAddr[PAGE_LSB +: PAGE_W]) &&
                     fwdReg_r == $past(reqAddr[REG_LSB +: REG_W]) && $past(reqValid);
  endproperty
  a_fwd_fields: assert property (p_fwd_fields) else $error("forwarded fields wrong");

  property p_port_rsvd; // R9
    @(posedge clk) disable iff (srst)
      reqValid && reqPath != PATH_MIIM && reqAddr[PORT_LSB +: PORT_W] != GLOBAL_PORT &&
      reqAddr[PAGE_LSB +: PAGE_W] == PORT_RSVD_PG_B |=> !fwdValid_r;
  endproperty
  a_port_rsvd: assert property (p_port_rsvd) else $error("reserved port page forwarded");

  property p_status_msb; // R7
    @(posedge clk) disable iff (srst)
      reqValid && !reqWrite && reqPath != PATH_MIIM && reqAddr == {8'h00, OFS_INT_STATUS}
      |-> ##2 rspRdata_r[TOP_BYTE_LUE] == $past(lookupEngineIrq, 2) &&
              rspRdata_r[TOP_BYTE_GPIO] == $past(gpioTsIrq, 2) && rspRdata_r[5:0] == 6'h00;
  endproperty
  a_status_msb: assert property (p_status_msb) else $error("status top byte wrong");

  property p_status_low; // R16
    @(posedge clk) disable iff (srst)
      reqValid && !reqWrite && reqPath != PATH_MIIM &&
      reqAddr == {8'h00, OFS_INT_STATUS + 8'h03} |-> ##2 rspRdata_r == 8'h00;
  endproperty
  a_status_low: assert property (p_status_low) else $error("reserved status bits set");

  property p_soft_reset; // R12
    @(posedge clk) disable iff (srst)
      reqValid && reqWrite && reqPath != PATH_MIIM && reqAddr == {8'h00, OFS_REV_RST} &&
      reqWdata[SWRST_BIT] |-> ##2 softReset_r [*8] ##1 (!softReset_r || $past(reqValid, 9));
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset pulse length wrong");

  property p_pin_off; // R13
    @(posedge clk) disable iff (srst)
      !pmeCtl_r[PME_EN_BIT] |=> powerEventOeN_r;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("power-event pin driven while off");

  property p_pin_level; // R13
    @(posedge clk) disable iff (srst)
      pmeCtl_r[PME_EN_BIT] && powerEventReq
      |=> !powerEventOeN_r && powerEventPin_r == $past(pmeCtl_r[PME_POL_BIT]);
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("power-event pin level wrong");

  property p_mask; // R17
    @(posedge clk) disable iff (srst)
      ((intStatus_r[SRC_LUE_BIT] && !intMask_r[SRC_LUE_BIT]) ||
       (intStatus_r[SRC_GPIO_BIT] && !intMask_r[SRC_GPIO_BIT])) |=> globalIrq_r;
  endproperty
  a_mask: assert property (p_mask) else $error("unmasked request not raised");

  property p_pme_rsvd; // R18
    @(posedge clk) disable iff (srst)
      s1Valid_r && !s1Write_r && s1Region_r == RG_LOCAL && s1Reg_r == OFS_PME_CTL
      |=> rspRdata_r[7:2] == 6'h00;
  endproperty
  a_pme_rsvd: assert property (p_pme_rsvd) else $error("reserved pin control bits set");

  c_soft_reset: cover property (@(posedge clk) disable iff (srst) $rose(softReset_r));
  c_refused:    cover property (@(posedge clk) disable iff (srst) rspValid_r && rspError_r);
  c_irq:        cover property (@(posedge clk) disable iff (srst) $rose(globalIrq_r));
  c_forward:    cover property (@(posedge clk) disable iff (srst) fwdValid_r && fwdWrite_r);

endmodule

//--- switch_regs_pkg.sv
// shared constants and types for the management register front end
// assumes a single 100 MHz clock and byte-wide management accesses
package switch_regs_pkg;

  // address layout: port field, page field, register field
  localparam int ADDR_W         = 16;
  localparam int ADDR_TOP_BIT   = 15;          // always driven zero by the host
  localparam int PORT_LSB       = 12;
  localparam int PORT_W         = 4;
  localparam int PAGE_LSB       = 8;
  localparam int PAGE_W         = 4;
  localparam int REG_LSB        = 0;
  localparam int REG_W          = 8;

  // port and page codes
  localparam logic [3:0] GLOBAL_PORT     = 4'h0;
  localparam logic [3:0] PORT_LAST       = 4'h7;
  localparam logic [3:0] GLB_OP_PAGE     = 4'h0;
  localparam logic [3:0] GLB_PAGE_LAST   = 4'h5;  // pages above are reserved
  localparam logic [3:0] PORT_PHY_PAGE   = 4'h1;
  localparam logic [3:0] PORT_RSVD_PG_A  = 4'h2;
  localparam logic [3:0] PORT_RSVD_PG_B  = 4'h7;
  localparam logic [3:0] PORT_RSVD_PG_HI = 4'hd;  // d..f reserved

  // byte offsets inside the global operation page
  localparam logic [7:0] OFS_CHIP_ID0    = 8'h00;
  localparam logic [7:0] OFS_CHIP_ID1    = 8'h01;
  localparam logic [7:0] OFS_CHIP_ID2    = 8'h02;
  localparam logic [7:0] OFS_REV_RST     = 8'h03;
  localparam logic [7:0] OFS_PME_CTL     = 8'h06;
  localparam logic [7:0] OFS_INT_STATUS  = 8'h10;  // four bytes, msb first
  localparam logic [7:0] OFS_INT_MASK    = 8'h14;  // four bytes, msb first

  // field positions
  localparam int REV_LSB        = 4;
  localparam int SWRST_BIT      = 0;
  localparam int PME_EN_BIT     = 1;
  localparam int PME_POL_BIT    = 0;
  localparam int SRC_LUE_BIT    = 1;   // bit 31 of the word, bit 7 of its top byte
  localparam int SRC_GPIO_BIT   = 0;   // bit 30 of the word, bit 6 of its top byte
  localparam int TOP_BYTE_LUE   = 7;
  localparam int TOP_BYTE_GPIO  = 6;

  // reset values
  localparam logic [1:0] PME_CTL_RST     = 2'h0;
  localparam logic [1:0] INT_MASK_RST    = 2'h0;
  localparam logic [1:0] INT_STATUS_RST  = 2'h0;

  // soft reset pulse length
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SWRST_TIME_NS  = 80;
  localparam int SWRST_CYCLES   = (SWRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SWRST_CNT_W    = 4;

  // management path that carries a request
  typedef enum logic [1:0] {PATH_SPI, PATH_I2C, PATH_INBAND, PATH_MIIM} mgmt_path_t;

  // what the front end does with an address
  typedef enum logic [1:0] {RG_LOCAL, RG_FORWARD, RG_RESERVED, RG_REFUSED} region_t;

endpackage

//--- power_event_pin_drive.sv
// drives the power-event pin from an internal request
// assumes enable and polarity come from the register bank on the same clock
`timescale 1ns/100ps
module power_event_pin_drive
  import switch_regs_pkg::*;
(
  input  wire logic clk,        // system clock
  input  wire logic srst,       // synchronous reset, active high
  input  wire logic pinEnable,  // output enable bit
  input  wire logic pinPolHigh, // 1: active high, 0: active low
  input  wire logic request,    // power event pending
  output logic      pinOut_r,   // pin level
  output logic      pinOeN_r    // output enable, low while driving
);

  logic pinOut_nxt;  // next pin level
  logic pinOeN_nxt;  // next output enable

  // pin level follows the request in the chosen sense; released when disabled
  always_comb begin
    pinOeN_nxt = ~pinEnable;
    if (pinEnable) begin
      pinOut_nxt = pinPolHigh ? request : ~request;
    end else begin
      pinOut_nxt = 1'b0;
    end
  end

  // register the pin so it comes straight from a flop
  always_ff @(posedge clk) begin
    if (srst) begin
      pinOut_r <= 1'b0;
      pinOeN_r <= 1'b1;
    end else begin
      pinOut_r <= pinOut_nxt;
      pinOeN_r <= pinOeN_nxt;
    end
  end

endmodule

//--- fwd_fabric_model.sv
// downstream register fabric model answering forwarded byte accesses
// assumes the front end's registered forward fields on the same clock
`timescale 1ns/100ps
module fwd_fabric_model (
  input  wire logic       clk,      // system clock
  input  wire logic       fwdValid, // forward strobe
  input  wire logic [3:0] port,     // port field
  input  wire logic [3:0] page,     // page field
  input  wire logic [7:0] regSel,   // register field
  output logic      [7:0] rdata     // read byte
);
  logic [7:0] junk = 8'h00; // changes every cycle so stale data never matches
  // pattern generator for cycles without an access
  always @(posedge clk) junk <= junk + 8'h5b;
  // answer combinationally while strobed, junk otherwise
  assign rdata = fwdValid ? ({page, port} ^ regSel) : junk;
endmodule

//--- test_switch_register_space_global_ctrl.sv
// self-checking bench for the management register front end
// assumes a 100 MHz clock and the fabric model on the forward side
`timescale 1ns/100ps
module test_switch_register_space_global_ctrl;
  import switch_regs_pkg::*;
  logic clk = 1'b0, srst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, sawFwd = 1'b0;
  logic [15:0] reqAddr = 16'h0000, capA, tA;
  logic [7:0] reqWdata = 8'h00, fwdRdata, capW, rd, d;
  logic [3:0] pg;
  logic lookup_engine = 1'b0, gts = 1'b0, pwrReq = 1'b0, er, wr, capWr;
  logic rspValid_r, fwdValid_r, fwdWrite_r, softReset_r, globalIrq_r, pin, oeN, rspError_r;
  logic [7:0] rspRdata_r, fwdReg_r, fwdWdata_r;
  logic [3:0] fwdPort_r, fwdPage_r;
  mgmt_path_t reqPath = PATH_SPI, p;
  int fail_count = 0, n_compared = 0, n;
  logic [7:0] ids[4] = '{8'h21, 8'h43, 8'h65, 8'h70};
  logic [3:0] okPg[11] = '{0, 1, 3, 4, 5, 6, 8, 9, 4'ha, 4'hb, 4'hc};
  logic [3:0] rsvPg[5] = '{2, 7, 4'hd, 4'he, 4'hf};
  switch_register_space_global_ctrl #(.CHIP_ID0(8'h21), .CHIP_ID1(8'h43), .CHIP_ID2(8'h65),
    .REV_ID(4'h7)) u_dut (.clk(clk), .srst(srst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqPath(reqPath), .rspValid_r(rspValid_r),
    .rspRdata_r(rspRdata_r), .rspError_r(rspError_r), .fwdValid_r(fwdValid_r),
    .fwdWrite_r(fwdWrite_r), .fwdPort_r(fwdPort_r), .fwdPage_r(fwdPage_r),
    .fwdReg_r(fwdReg_r), .fwdWdata_r(fwdWdata_r), .fwdRdata(fwdRdata),
    .lookupEngineIrq(lookup_engine), .gpioTsIrq(gts), .powerEventReq(pwrReq),
    .softReset_r(softReset_r), .globalIrq_r(globalIrq_r), .powerEventPin_r(pin),
    .powerEventOeN_r(oeN));
  fwd_fabric_model u_fab (.clk(clk), .fwdValid(fwdValid_r), .port(fwdPort_r),
    .page(fwdPage_r), .regSel(fwdReg_r), .rdata(fwdRdata));
  always #5 clk = ~clk;
  // capture what was forwarded downstream
  always @(posedge clk) begin
    sawFwd <= fwdValid_r;
    if (fwdValid_r) begin
      capA <= {fwdPort_r, fwdPage_r, fwdReg_r};
      capW <= fwdWdata_r;
      capWr <= fwdWrite_r;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // one byte access, held one cycle, answer awaited under a bound
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] dd,
                     input mgmt_path_t pp);
    int k;
    @(posedge clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr <= a;
    reqWdata <= dd;
    reqPath <= pp;
    @(posedge clk);
    reqValid <= 1'b0;
    k = 1;
    do begin
      @(posedge clk);
      #1 k++;
    end while (rspValid_r !== 1'b1 && k < 6);
    rd = rspRdata_r;
    er = rspError_r;
    chk(k, 2);
  endtask
  function automatic logic [7:0] expFwd(input logic [15:0] a);
    return {a[11:8], a[15:12]} ^ a[7:0];
  endfunction
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    n = $urandom(91156);
    settle(16);
    srst <= 1'b0;
    settle(1);
    chk({oeN, softReset_r, globalIrq_r}, 3'h4);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 16'(i), 8'h00, PATH_I2C);
      chk(rd, ids[i]);
    end
    $display("identity test done");
    acc(1'b1, 16'h0003, rd | 8'h01, PATH_SPI);
    n = 0;
    while (softReset_r === 1'b1 && n < 20) begin
      n++;
      settle(1);
    end
    chk(n, SWRST_CYCLES);
    acc(1'b0, 16'h0003, 8'h00, PATH_INBAND);
    chk(rd, 8'h70);
    $display("soft reset test done");
    for (int i = 0; i < 3; i++) begin
      d = 8'(i + 1);
      pwrReq <= 1'($urandom);
      acc(1'b0, 16'h0006, 8'h00, PATH_SPI);
      acc(1'b1, 16'h0006, (rd & 8'hfc) | d, PATH_SPI);
      settle(3);
      chk({oeN, d[1] ? pin : 1'b0}, {~d[1], d[1] & (pwrReq ~^ d[0])});
      acc(1'b0, 16'h0006, 8'h00, PATH_SPI);
      chk(rd, d);
    end
    $display("pin test done");
    for (int i = 0; i < 4; i++) begin
      lookup_engine <= i[1];
      gts <= i[0];
      settle(3);
      chk(globalIrq_r, |i[1:0]);
      acc(1'b0, 16'h0010, 8'h00, PATH_SPI);
      chk(rd, {i[1:0], 6'h00});
      acc(1'b0, 16'h0013, 8'h00, PATH_I2C);
      chk(rd, 8'h00);
    end
    acc(1'b0, 16'h0014, 8'h00, PATH_SPI);
    acc(1'b1, 16'h0014, rd | 8'hc0, PATH_SPI);
    acc(1'b0, 16'h0014, 8'h00, PATH_SPI);
    chk({rd, globalIrq_r}, 9'h180);
    acc(1'b1, 16'h0014, (rd & 8'h3f) | 8'h40, PATH_SPI);
    settle(3);
    chk(globalIrq_r, 1'b1);
    $display("status test done");
    for (int i = 0; i < 40; i++) begin
      pg = okPg[$urandom % 11];
      tA = {1'b0, 3'(1 + $urandom % 7), pg, 8'($urandom)};
      wr = 1'($urandom);
      d = 8'($urandom);
      p = mgmt_path_t'($urandom % 4);
      acc(wr, tA, d, p);
      if (p == PATH_MIIM && pg != PORT_PHY_PAGE) chk({er, sawFwd, rd}, 10'h200);
      else begin
        chk({er, sawFwd, capWr, rd}, {2'b01, wr, wr ? 8'h00 : expFwd(tA)});
        chk({capA, wr ? capW : d}, {tA, d});
      end
    end
    $display("forward test done");
    for (int i = 0; i < 10; i++) begin
      tA = i < 5 ? {8'(6 + $urandom % 10), 8'($urandom)}
                 : {1'b0, 3'(1 + $urandom % 7), rsvPg[i - 5], 8'($urandom)};
      acc(1'b0, tA, 8'($urandom), PATH_SPI);
      chk({er, sawFwd, rd}, 10'h000);
    end
    $display("reserved test done");
    tally_and_finish();
  end
endmodule
